//--- rtl/acr_pkg.sv
// package: register map, field layout, defaults and carrier types
package acr_pkg;
  // register addresses (six-bit field of the command byte)
  localparam int IDX_W = 2;
  localparam int NUM_CHAN = 4;
  localparam int NUM_SETUP = 4;
  localparam logic [5:0] ADDR_ID = 6'h07;
  localparam logic [5:0] ADDR_CH = 6'h10;
  localparam logic [5:0] ADDR_SETUP = 6'h20;
  localparam logic [5:0] ADDR_FILT = 6'h28;
  localparam logic [5:0] ADDR_OFFS = 6'h30;
  localparam logic [5:0] ADDR_GAIN = 6'h38;
  // command byte bits
  localparam int CMD_WEN = 7;
  localparam int CMD_RW = 6;
  // data phase lengths in bits
  localparam logic [4:0] LEN_8 = 5'h08;
  localparam logic [4:0] LEN_16 = 5'h10;
  localparam logic [4:0] LEN_24 = 5'h18;
  // defaults and writable-bit masks
  localparam logic [15:0] CH0_RESET = 16'h8001;
  localparam logic [15:0] CHN_RESET = 16'h0001;
  localparam logic [15:0] CH_MASK = 16'hf3ff;
  localparam logic [15:0] SETUP_RESET = 16'h1320;
  localparam logic [15:0] SETUP_MASK = 16'h1fb0;
  localparam logic [15:0] FILT_RESET = 16'h0000;
  localparam logic [15:0] FILT_MASK = 16'h8f7f;
  localparam logic [23:0] OFFS_RESET = 24'h800000;
  // field positions
  localparam int CH_EN = 15;
  localparam int CH_SETUP_LO = 12;
  localparam int CH_POS_LO = 5;
  localparam int CH_NEG_LO = 0;
  localparam int SU_POL = 12;
  localparam int SU_RBP = 11;
  localparam int SU_RBN = 10;
  localparam int SU_ABP = 9;
  localparam int SU_ABN = 8;
  localparam int SU_BURN = 7;
  localparam int SU_REF_LO = 4;
  localparam int FI_MAP = 15;
  localparam int FI_ENH_EN = 11;
  localparam int FI_ENH_LO = 8;
  localparam int FI_ORD_LO = 5;
  localparam int FI_ODR_LO = 0;
  // resync: consecutive ones on the data input
  localparam logic [6:0] RESYNC_ONES = 7'h40;
  // conversion slot at the top rate (250 kSPS) on a 40 ns clock
  localparam int CONV_PERIOD_NS = 4000;
  localparam int CLK_PERIOD_NS = 40;
  localparam int CONV_CYCLES = CONV_PERIOD_NS / CLK_PERIOD_NS;
  // link states, gray along cmd -> write / cmd -> read
  typedef enum logic [1:0] {
    LNK_CMD = 2'b00,
    LNK_WRITE = 2'b01,
    LNK_READ = 2'b10
  } acr_link_state_t;
  typedef struct packed {
    logic chan_enable_bit;
    logic [2:0] setup_sel;
    logic [4:0] pos_input_select;
    logic [4:0] neg_input_select;
  } acr_chan_t;
  typedef struct packed {
    logic polarity_coding;
    logic ref_pos_buffer_en;
    logic ref_neg_buffer_en;
    logic input_pos_buffer_en;
    logic input_neg_buffer_en;
    logic burnout_current_en;
    logic [1:0] ref_source_sel;
    logic third_order_map;
    logic enhanced_filter_en;
    logic [2:0] enhanced_filter_choice;
    logic [1:0] filter_order_sel;
    logic [4:0] out_rate_sel;
    logic [23:0] offset_coeff;
    logic [23:0] gain_coeff;
  } acr_setup_t;
  typedef struct packed {
    logic continuous_conv;
    logic internal_osc;
    logic crc_en;
    logic status_append;
  } acr_mode_t;
  localparam acr_mode_t MODE_RESET = 4'hc;
endpackage

//--- rtl/acr_config_bank.sv
// config register bank behind a mode 3 serial link, with channel sequencer
// Behaviour
// (R01) every transaction opens with a command byte
// (R02) address field picks the target register
// (R03) after data phase, expect next command
// (R04) mode 3: drive falling, sample rising
// (R05) data length 8, 16 or 24 by address
// (R06) read-only part identifier at 0x07
// (R07) host should read identifier to verify link
// (R08) 64 ones on data input resets all
// (R09) chip select high aborts transfer, idles link
// (R10) reset: channel 0 on, setup 0, inputs 0/1
// (R11) reset: internal reference, input buffers on
// (R12) reset: fifth plus first order, top rate
// (R13) reset: continuous, internal oscillator, no crc
// (R14) four channels, four setups, free mapping
// (R15) channel register fields: enable, setup, inputs
// (R16) sequencer steps enabled channels ascending
// (R17) setup: coding, filter, offset, gain registers
// (R18) polarity bit selects bipolar or unipolar coding
// (R19) reference source: internal, external, supply
// (R20) separate input and reference buffer enables
// (R21) filter order, rate, enhanced filter fields
// (R22) gain loads factory value, calibration replaces
// (R23) offset resets mid-scale, calibration replaces
// (R24) reserved bits ignore writes, read zero
`timescale 1ns/100ps
module acr_config_bank #(
  parameter logic [15:0] PART_ID = 16'h5a5a, // arbitrary value
  parameter logic [23:0] FACTORY_GAIN = 24'h400000, // arbitrary value
  parameter int CONV_CYCLES = acr_pkg::CONV_CYCLES
) (
  // system clock and reset
  input wire logic clk,
  input wire logic resetn,
  // serial link pins
  input wire logic sclk_link,
  input wire logic cs_n,
  input wire logic din,
  output logic dout,
  output logic dout_oe,
  // calibration engine results
  input wire logic cal_offset_load,
  input wire logic cal_gain_load,
  input wire logic [1:0] cal_setup,
  input wire logic [23:0] cal_value,
  // sequencer view toward the converter
  output logic [1:0] active_chan,
  output acr_pkg::acr_chan_t active_cfg,
  output acr_pkg::acr_setup_t active_setup,
  output acr_pkg::acr_mode_t mode_cfg
);

  localparam int IW = acr_pkg::IDX_W;
  localparam int NC = acr_pkg::NUM_CHAN;

  // register storage, clk domain
  logic [15:0] chan_reg [NC]; // channel words
  logic [15:0] setup_reg [NC]; // coding/reference words
  logic [15:0] filt_reg [NC]; // filter words
  logic [23:0] offs_reg [NC]; // offset coefficients
  logic [23:0] gain_reg [NC]; // gain coefficients

  // ---------------- link side, sclk_link domain ----------------

  logic frame_rst_n; // cleared by reset or deselect
  acr_pkg::acr_link_state_t state_reg;
  logic [4:0] bit_cnt_reg; // bits taken in this phase
  logic [4:0] len_reg; // length of this phase
  logic [5:0] addr_reg; // address of data phase
  logic [23:0] shift_reg; // incoming bits
  logic [23:0] rd_shift_reg; // outgoing bits, msb first
  logic [6:0] ones_reg; // run of ones on din
  logic dout_reg;
  logic wr_tog_reg; // flips per completed write
  logic rst_tog_reg; // flips per resync pattern
  logic [5:0] wr_addr_hold;
  logic [23:0] wr_data_hold;
  logic [7:0] cmd_byte; // byte as of this edge
  logic [23:0] in_word; // data word as of this edge
  logic last_bit;
  logic resync_hit;
  logic [23:0] rd_word; // left aligned read value
  logic [IW-1:0] rd_idx;

  // deselect acts as an async clear of the frame logic, since the
  // link clock is parked outside frames and cannot sample it
  assign frame_rst_n = resetn & ~cs_n; // [R09]
  assign cmd_byte = {shift_reg[6:0], din};
  assign in_word = {shift_reg[22:0], din};
  assign last_bit = (bit_cnt_reg == len_reg - 5'h01);
  assign resync_hit = din &
    (ones_reg == acr_pkg::RESYNC_ONES - 7'h01); // [R08]
  assign rd_idx = cmd_byte[IW-1:0];

  // true when an address falls in a four-entry block
  function automatic logic in_blk(input logic [5:0] a,
                                  input logic [5:0] base);
    in_blk = (a[5:IW] == base[5:IW]);
  endfunction

  // data phase length from the address
  function automatic logic [4:0] len_of(input logic [5:0] a);
    len_of = acr_pkg::LEN_8; // unmapped: one byte
    if (a == acr_pkg::ADDR_ID || in_blk(a, acr_pkg::ADDR_CH) ||
        in_blk(a, acr_pkg::ADDR_SETUP) ||
        in_blk(a, acr_pkg::ADDR_FILT)) begin
      len_of = acr_pkg::LEN_16; // [R05]
    end else if (in_blk(a, acr_pkg::ADDR_OFFS) ||
                 in_blk(a, acr_pkg::ADDR_GAIN)) begin
      len_of = acr_pkg::LEN_24; // [R05]
    end
  endfunction

  // read mux; the words are quasi-static, they only move on a write
  // that this same link finished well before, on a calibration load, or on a reset
  always_comb begin
    rd_word = '0; // unmapped reads return zero
    if (cmd_byte[5:0] == acr_pkg::ADDR_ID) begin
      rd_word = {PART_ID, 8'h00}; // [R06]
    end else if (in_blk(cmd_byte[5:0], acr_pkg::ADDR_CH)) begin
      rd_word = {chan_reg[rd_idx], 8'h00}; // [R02]
    end else if (in_blk(cmd_byte[5:0], acr_pkg::ADDR_SETUP)) begin
      rd_word = {setup_reg[rd_idx], 8'h00};
    end else if (in_blk(cmd_byte[5:0], acr_pkg::ADDR_FILT)) begin
      rd_word = {filt_reg[rd_idx], 8'h00};
    end else if (in_blk(cmd_byte[5:0], acr_pkg::ADDR_OFFS)) begin
      rd_word = offs_reg[rd_idx];
    end else if (in_blk(cmd_byte[5:0], acr_pkg::ADDR_GAIN)) begin
      rd_word = gain_reg[rd_idx];
    end
  end

  // frame state machine, samples din on the rising edge
  always_ff @(posedge sclk_link or negedge frame_rst_n) begin // [R04]
    if (!frame_rst_n) begin
      state_reg <= acr_pkg::LNK_CMD; // [R01] [R09]
      bit_cnt_reg <= 5'h00;
      len_reg <= acr_pkg::LEN_8;
      addr_reg <= 6'h00;
      shift_reg <= 24'h000000;
      rd_shift_reg <= 24'h000000;
    end else begin
      shift_reg <= in_word;
      bit_cnt_reg <= bit_cnt_reg + 5'h01;
      if (state_reg == acr_pkg::LNK_READ) begin
        rd_shift_reg <= rd_shift_reg << 1;
      end
      if (resync_hit) begin
        // resync pattern wins over whatever phase was running
        state_reg <= acr_pkg::LNK_CMD; // [R08]
        bit_cnt_reg <= 5'h00;
        len_reg <= acr_pkg::LEN_8;
      end else if (last_bit) begin
        bit_cnt_reg <= 5'h00;
        case (state_reg)
          acr_pkg::LNK_CMD: begin
            // a byte with the enable bit set is not a command
            if (!cmd_byte[acr_pkg::CMD_WEN]) begin // [R01]
              addr_reg <= cmd_byte[5:0]; // [R02]
              len_reg <= len_of(cmd_byte[5:0]); // [R05]
              if (cmd_byte[acr_pkg::CMD_RW]) begin
                state_reg <= acr_pkg::LNK_READ;
                rd_shift_reg <= rd_word;
              end else begin
                state_reg <= acr_pkg::LNK_WRITE;
              end
            end
          end
          default: begin
            // data phase over: back to expecting a command
            state_reg <= acr_pkg::LNK_CMD; // [R03]
            len_reg <= acr_pkg::LEN_8;
          end
        endcase
      end
    end
  end

  // run of ones; clears on a hit so a long high run resets again and again
  always_ff @(posedge sclk_link or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      ones_reg <= 7'h00;
    end else if (!din || resync_hit) begin
      ones_reg <= 7'h00;
    end else begin
      ones_reg <= ones_reg + 7'h01; // [R08]
    end
  end

  // events toward clk; these survive deselect so none is lost
  always_ff @(posedge sclk_link or negedge resetn) begin
    if (!resetn) begin
      wr_tog_reg <= 1'b0;
      rst_tog_reg <= 1'b0;
      wr_addr_hold <= 6'h00;
      wr_data_hold <= 24'h000000;
    end else if (resync_hit) begin
      rst_tog_reg <= ~rst_tog_reg; // [R08]
    end else if (state_reg == acr_pkg::LNK_WRITE && last_bit) begin
      wr_tog_reg <= ~wr_tog_reg;
      wr_addr_hold <= addr_reg; // [R02]
      wr_data_hold <= in_word;
    end
  end

  // output bit changes on the falling edge
  always_ff @(negedge sclk_link or negedge frame_rst_n) begin // [R04]
    if (!frame_rst_n) begin
      dout_reg <= 1'b0;
    end else if (state_reg == acr_pkg::LNK_READ) begin
      dout_reg <= rd_shift_reg[23]; // [R05]
    end else begin
      dout_reg <= 1'b0;
    end
  end

  assign dout = dout_reg;
  assign dout_oe = frame_rst_n; // driven only while selected

  // ---------------- core side, clk domain ----------------

  logic [2:0] wr_sync_reg; // [0] feeds [1] only
  logic [2:0] rst_sync_reg;
  logic wr_pulse; // one cycle per finished write
  logic soft_rst; // one cycle per resync pattern

  // two-flop synchronisers plus an edge stage
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_sync_reg <= 3'h0;
      rst_sync_reg <= 3'h0;
    end else begin
      wr_sync_reg <= {wr_sync_reg[1:0], wr_tog_reg};
      rst_sync_reg <= {rst_sync_reg[1:0], rst_tog_reg};
    end
  end

  // the hold words are stable a full byte before the next write
  assign wr_pulse = wr_sync_reg[2] ^ wr_sync_reg[1];
  assign soft_rst = rst_sync_reg[2] ^ rst_sync_reg[1]; // [R08]

  // per setup/channel entry storage
  for (genvar g = 0; g < NC; g++) begin : g_entry
    localparam logic [5:0] GI = 6'(g);

    // channel, coding/reference and filter words
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        chan_reg[g] <= (g == 0) ? acr_pkg::CH0_RESET
                                : acr_pkg::CHN_RESET; // [R10]
        setup_reg[g] <= acr_pkg::SETUP_RESET; // [R11]
        filt_reg[g] <= acr_pkg::FILT_RESET; // [R12]
      end else if (soft_rst) begin
        chan_reg[g] <= (g == 0) ? acr_pkg::CH0_RESET
                                : acr_pkg::CHN_RESET; // [R08] [R10]
        setup_reg[g] <= acr_pkg::SETUP_RESET; // [R11]
        filt_reg[g] <= acr_pkg::FILT_RESET; // [R12]
      end else if (wr_pulse) begin
        // masks drop writes to reserved positions
        if (wr_addr_hold == acr_pkg::ADDR_CH + GI) begin
          chan_reg[g] <= wr_data_hold[15:0] & acr_pkg::CH_MASK; // [R15] [R24]
        end
        if (wr_addr_hold == acr_pkg::ADDR_SETUP + GI) begin
          setup_reg[g] <= wr_data_hold[15:0] & acr_pkg::SETUP_MASK; // [R17] [R24]
        end
        if (wr_addr_hold == acr_pkg::ADDR_FILT + GI) begin
          filt_reg[g] <= wr_data_hold[15:0] & acr_pkg::FILT_MASK; // [R21] [R24]
        end
      end
    end

    // coefficients; a host write beats a calibration result
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        offs_reg[g] <= acr_pkg::OFFS_RESET; // [R23]
        gain_reg[g] <= FACTORY_GAIN; // [R22]
      end else if (soft_rst) begin
        offs_reg[g] <= acr_pkg::OFFS_RESET; // [R23]
        gain_reg[g] <= FACTORY_GAIN; // [R22]
      end else begin
        if (wr_pulse && wr_addr_hold == acr_pkg::ADDR_OFFS + GI) begin
          offs_reg[g] <= wr_data_hold; // [R23]
        end else if (cal_offset_load && cal_setup == GI[1:0]) begin
          offs_reg[g] <= cal_value; // [R23]
        end
        if (wr_pulse && wr_addr_hold == acr_pkg::ADDR_GAIN + GI) begin
          gain_reg[g] <= wr_data_hold; // [R22]
        end else if (cal_gain_load && cal_setup == GI[1:0]) begin
          gain_reg[g] <= cal_value; // [R22]
        end
      end
    end
  end

  // ---------------- channel sequencer ----------------

  logic [15:0] conv_cnt_reg; // cycles into this slot
  logic conv_tick;
  logic [IW-1:0] active_reg;
  logic [IW-1:0] nxt_chan;
  logic [IW-1:0] sel_setup; // setup of the active channel

  assign conv_tick = (conv_cnt_reg == 16'(CONV_CYCLES - 1));

  // conversion slot timer
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      conv_cnt_reg <= 16'h0000;
    end else if (conv_tick || soft_rst) begin
      conv_cnt_reg <= 16'h0000;
    end else begin
      conv_cnt_reg <= conv_cnt_reg + 16'h0001;
    end
  end

  // next enabled channel above the active one, wrapping to 0
  always_comb begin
    logic found;
    logic [IW-1:0] cand;
    found = 1'b0;
    cand = '0;
    nxt_chan = active_reg; // nothing enabled: hold
    for (int i = 1; i <= NC; i++) begin
      cand = active_reg + IW'(i);
      if (!found && chan_reg[cand][acr_pkg::CH_EN]) begin
        nxt_chan = cand; // [R16]
        found = 1'b1;
      end
    end
  end

  // active channel pointer
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      active_reg <= '0; // [R10]
    end else if (soft_rst) begin
      active_reg <= '0;
    end else if (conv_tick) begin
      active_reg <= nxt_chan; // [R16]
    end
  end

  // setup_sel is three bits; only four setups exist, so wrap
  assign sel_setup = chan_reg[active_reg][acr_pkg::CH_SETUP_LO +: IW];

  // registered view of the active channel and its setup
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      active_chan <= '0;
      active_cfg <= '0;
      active_setup <= '0;
    end else begin
      active_chan <= active_reg;
      active_cfg <= '{ // [R14] [R15]
        chan_enable_bit: chan_reg[active_reg][acr_pkg::CH_EN],
        setup_sel: chan_reg[active_reg][acr_pkg::CH_SETUP_LO +: 3],
        pos_input_select: chan_reg[active_reg][acr_pkg::CH_POS_LO +: 5],
        neg_input_select: chan_reg[active_reg][acr_pkg::CH_NEG_LO +: 5]
      };
      active_setup <= '{ // [R17] [R18] [R19] [R20] [R21]
        polarity_coding: setup_reg[sel_setup][acr_pkg::SU_POL],
        ref_pos_buffer_en: setup_reg[sel_setup][acr_pkg::SU_RBP],
        ref_neg_buffer_en: setup_reg[sel_setup][acr_pkg::SU_RBN],
        input_pos_buffer_en: setup_reg[sel_setup][acr_pkg::SU_ABP],
        input_neg_buffer_en: setup_reg[sel_setup][acr_pkg::SU_ABN],
        burnout_current_en: setup_reg[sel_setup][acr_pkg::SU_BURN],
        ref_source_sel: setup_reg[sel_setup][acr_pkg::SU_REF_LO +: 2],
        third_order_map: filt_reg[sel_setup][acr_pkg::FI_MAP],
        enhanced_filter_en: filt_reg[sel_setup][acr_pkg::FI_ENH_EN],
        enhanced_filter_choice:
          filt_reg[sel_setup][acr_pkg::FI_ENH_LO +: 3],
        filter_order_sel: filt_reg[sel_setup][acr_pkg::FI_ORD_LO +: 2],
        out_rate_sel: filt_reg[sel_setup][acr_pkg::FI_ODR_LO +: 5],
        offset_coeff: offs_reg[sel_setup],
        gain_coeff: gain_reg[sel_setup]
      };
    end
  end

  // operating mode defaults; no write path in this bank
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mode_cfg <= acr_pkg::MODE_RESET; // [R13]
    end else if (soft_rst) begin
      mode_cfg <= acr_pkg::MODE_RESET; // [R13]
    end
  end

  // ---------------- checks ----------------

  sequence s_id_cmd;
    state_reg == acr_pkg::LNK_CMD && last_bit && !resync_hit &&
      cmd_byte == {1'b0, 1'b1, acr_pkg::ADDR_ID};
  endsequence

  a_id_load: assert property (@(posedge sclk_link)
    disable iff (!frame_rst_n) s_id_cmd |=>
      state_reg == acr_pkg::LNK_READ && len_reg == acr_pkg::LEN_16 &&
      rd_shift_reg[23:8] == PART_ID) // [R06]
    else $error("identifier read not loaded");

  a_read_hold: assert property (@(posedge sclk_link)
    disable iff (!frame_rst_n) s_id_cmd ##1 !resync_hit |=>
      (state_reg == acr_pkg::LNK_READ)[*8]) // [R05]
    else $error("read phase ended early");

  a_wr_return: assert property (@(posedge sclk_link)
    disable iff (!frame_rst_n)
    state_reg == acr_pkg::LNK_WRITE && last_bit && !resync_hit |=>
      state_reg == acr_pkg::LNK_CMD && bit_cnt_reg == 5'h00) // [R03]
    else $error("write phase did not return to command");

  a_resync_idle: assert property (@(posedge sclk_link)
    disable iff (!frame_rst_n) resync_hit |=>
      state_reg == acr_pkg::LNK_CMD && ones_reg == 7'h00) // [R08]
    else $error("resync pattern did not idle link");

  a_wr_lands: assert property (@(posedge clk) disable iff (!resetn)
    wr_pulse && !soft_rst && wr_addr_hold == acr_pkg::ADDR_CH + 6'h01 |=>
      {8'h00, chan_reg[1]} ==
      ($past(wr_data_hold) & {8'h00, acr_pkg::CH_MASK})) // [R02]
    else $error("channel write not stored");

  a_soft_defaults: assert property (@(posedge clk) disable iff (!resetn)
    soft_rst |=> chan_reg[0] == acr_pkg::CH0_RESET &&
      setup_reg[0] == acr_pkg::SETUP_RESET &&
      filt_reg[0] == acr_pkg::FILT_RESET &&
      offs_reg[0] == acr_pkg::OFFS_RESET && active_reg == '0) // [R10]
    else $error("resync did not restore defaults");

  a_reserved_zero: assert property (@(posedge clk) disable iff (!resetn)
    (setup_reg[1] & ~acr_pkg::SETUP_MASK) == 16'h0000 &&
    (chan_reg[1] & ~acr_pkg::CH_MASK) == 16'h0000) // [R24]
    else $error("reserved bits set");

  a_seq_step: assert property (@(posedge clk) disable iff (!resetn)
    conv_tick && !soft_rst |=> active_reg == $past(nxt_chan)) // [R16]
    else $error("sequencer did not step");

  a_gain_cal: assert property (@(posedge clk) disable iff (!resetn)
    cal_gain_load && cal_setup == 2'h2 && !soft_rst &&
    !(wr_pulse && wr_addr_hold == acr_pkg::ADDR_GAIN + 6'h02) |=>
      gain_reg[2] == $past(cal_value)) // [R22]
    else $error("gain calibration not stored");

endmodule

//--- tb/acr_host_model.sv
// host serial master model: mode 3 frames toward the config bank
`timescale 1ns/100ps
module acr_host_model (
  // link pins toward the device
  output logic sclk_link,
  output logic cs_n,
  output logic din,
  input wire logic dout
);
  localparam int HALF_NS = 32; // 64 ns link clock, runs only in frames
  initial begin
    sclk_link = 1'b1; // idles high between frames
    cs_n = 1'b1;
    din = 1'b1;
  end
  // one bit: drive after the falling edge, sample at the rising
  task automatic bit_io(input logic b, output logic q);
    sclk_link = 1'b0;
    din = b;
    #(HALF_NS);
    sclk_link = 1'b1;
    q = dout;
    #(HALF_NS);
  endtask
  // full frame: command byte first, then data, msb first
  task automatic xfer(input logic [7:0] cmd, input int n,
    input logic [23:0] wd, output logic [23:0] rd, input bit keep);
    logic q;
    cs_n = 1'b0;
    #(HALF_NS);
    for (int i = 7; i >= 0; i--) bit_io(cmd[i], q);
    rd = 24'h000000;
    for (int i = n - 1; i >= 0; i--) begin
      bit_io(wd[i], q);
      rd = {rd[22:0], q};
    end
    // keep holds select low so the next command shares the frame
    if (!keep) begin
      cs_n = 1'b1;
      din = ~din; // released line must not show a stale level
    end
    #(HALF_NS);
  endtask
  // command then n ones, cut short by raising select
  task automatic part(input logic [7:0] cmd, input int n);
    logic q;
    cs_n = 1'b0;
    #(HALF_NS);
    for (int i = 7; i >= 0; i--) bit_io(cmd[i], q);
    repeat (n) bit_io(1'b1, q);
    cs_n = 1'b1;
    din = 1'b0;
    #(HALF_NS);
  endtask
endmodule

//--- tb/acr_config_bank_tb_top.sv
// testbench: register map, defaults, sequencer, abort and resync
`timescale 1ns/100ps
module acr_config_bank_tb_top;
  localparam int CONV = 4; // short slot keeps the sequencer run brief
  localparam logic [15:0] ID_VAL = 16'h3c96; // arbitrary value
  localparam logic [23:0] GAIN_VAL = 24'h5b3c70; // arbitrary value
  logic clk, resetn, sclk_link, cs_n, din, dout, dout_oe;
  logic cal_offset_load, cal_gain_load;
  logic [1:0] cal_setup, active_chan, last;
  logic [1:0] seq_exp [3];
  logic [23:0] cal_value, rd;
  acr_pkg::acr_chan_t active_cfg;
  acr_pkg::acr_setup_t active_setup;
  acr_pkg::acr_mode_t mode_cfg;
  int fail_count = 0;
  int checks_done = 0;
  initial clk = 1'b0;
  always #20 clk = ~clk;
  acr_config_bank #(.PART_ID(ID_VAL), .FACTORY_GAIN(GAIN_VAL),
    .CONV_CYCLES(CONV)) dut_u (.clk(clk), .resetn(resetn),
    .sclk_link(sclk_link), .cs_n(cs_n), .din(din), .dout(dout),
    .dout_oe(dout_oe), .cal_offset_load(cal_offset_load),
    .cal_gain_load(cal_gain_load), .cal_setup(cal_setup),
    .cal_value(cal_value), .active_chan(active_chan),
    .active_cfg(active_cfg), .active_setup(active_setup),
    .mode_cfg(mode_cfg));
  acr_host_model host_u (.sclk_link(sclk_link), .cs_n(cs_n), .din(din),
    .dout(dout));
  // compare and count; unknowns never match
  task automatic cmp(input string what, input logic [23:0] e,
    input logic [23:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic rreg(input logic [5:0] a, input int n,
    input logic [23:0] e);
    host_u.xfer({2'b01, a}, n, 24'h000000, rd, 1'b0);
    cmp("readback", e, rd);
  endtask
  // writes land in the clk domain a few cycles late, so wait
  task automatic wreg(input logic [5:0] a, input int n, input logic [23:0] v);
    host_u.xfer({2'b00, a}, n, v, rd, 1'b0);
    repeat (6) @(posedge clk);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    resetn = 1'b0;
    {cal_offset_load, cal_gain_load, cal_setup, cal_value} = '0;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(negedge clk);
    cmp("ch cfg", 24'h002001, {10'h0, active_cfg});
    cmp("bufs", 24'h13, {19'h0, active_setup[67:63]});
    cmp("ref sel", 24'h2, {22'h0, active_setup.ref_source_sel});
    cmp("order", 24'h0, {22'h0, active_setup.filter_order_sel});
    cmp("rate", 24'h0, {19'h0, active_setup.out_rate_sel});
    cmp("offs", 24'h800000, active_setup.offset_coeff);
    cmp("gain", GAIN_VAL, active_setup.gain_coeff);
    cmp("mode", 24'hc, {20'h0, mode_cfg});
    $display("test defaults done");
    cmp("oe idle", 24'h0, {23'h0, dout_oe});
    fork
      rreg(acr_pkg::ADDR_ID, 16, ID_VAL);
      begin
        #100;
        cmp("oe sel", 24'h1, {23'h0, dout_oe});
      end
    join
    // write then read in one frame: the link must re-arm for a command
    host_u.xfer({2'b00, acr_pkg::ADDR_ID}, 16, 24'h0, rd, 1'b1);
    rreg(acr_pkg::ADDR_ID, 16, ID_VAL);
    rreg(acr_pkg::ADDR_CH, 16, 24'h8001);
    rreg(acr_pkg::ADDR_OFFS, 24, 24'h800000);
    rreg(6'h3f, 8, 24'h00);
    $display("test reads done");
    for (int s = 0; s < 4; s++) begin
      wreg(acr_pkg::ADDR_SETUP + 6'(s), 16, 24'hffff);
      wreg(acr_pkg::ADDR_FILT + 6'(s), 16, 24'hffff);
      wreg(acr_pkg::ADDR_GAIN + 6'(s), 24, 24'ha5a5a0 + s);
      rreg(acr_pkg::ADDR_SETUP + 6'(s), 16, 24'h1fb0);
      rreg(acr_pkg::ADDR_FILT + 6'(s), 16, 24'h8f7f);
      rreg(acr_pkg::ADDR_GAIN + 6'(s), 24, 24'ha5a5a0 + s);
    end
    $display("test setups done");
    @(posedge clk);
    cal_setup <= 2'd2;
    cal_value <= 24'h123456;
    cal_offset_load <= 1'b1;
    @(posedge clk);
    cal_offset_load <= 1'b0;
    cal_gain_load <= 1'b1;
    @(posedge clk);
    cal_gain_load <= 1'b0;
    repeat (2) @(posedge clk);
    rreg(acr_pkg::ADDR_OFFS + 6'h02, 24, 24'h123456);
    rreg(acr_pkg::ADDR_GAIN + 6'h02, 24, 24'h123456);
    $display("test calibration done");
    wreg(acr_pkg::ADDR_CH + 6'h01, 16, 24'h9c43);
    wreg(acr_pkg::ADDR_CH + 6'h03, 16, 24'h8000);
    rreg(acr_pkg::ADDR_CH + 6'h01, 16, 24'h9043);
    seq_exp = '{2'd1, 2'd3, 2'd0};
    repeat (40) if (active_chan !== 2'd0) @(negedge clk);
    foreach (seq_exp[k]) begin
      last = active_chan;
      repeat (20) if (active_chan === last) @(negedge clk);
      cmp("seq", {22'h0, seq_exp[k]}, {22'h0, active_chan});
      @(negedge clk);
      if (k == 0) begin
        cmp("ch1 cfg", 24'h002443, {10'h0, active_cfg});
        cmp("su1 ref", 24'h1, {23'h0, active_setup.ref_pos_buffer_en});
      end
    end
    $display("test sequencer done");
    host_u.part(8'h11, 5); // abort a write in mid-data
    rreg(acr_pkg::ADDR_CH + 6'h01, 16, 24'h9043);
    rreg(acr_pkg::ADDR_ID, 16, ID_VAL);
    $display("test abort done");
    host_u.part(8'hff, 57); // 64 ones, one more to see the idle link
    repeat (8) @(posedge clk);
    rreg(acr_pkg::ADDR_GAIN + 6'h01, 24, GAIN_VAL);
    rreg(acr_pkg::ADDR_CH + 6'h01, 16, 24'h0001);
    rreg(acr_pkg::ADDR_SETUP + 6'h01, 16, 24'h1320);
    rreg(acr_pkg::ADDR_OFFS + 6'h02, 24, 24'h800000);
    $display("test resync done");
    close_out();
  end
  // watchdog: the whole run needs well under a millisecond
  initial begin
    #1000000;
    fail_count++;
    close_out();
  end
endmodule
